// [src/pvm_pkg.sv]
package pvm_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int KEY_W    = 6;
  localparam int NUM_KEYS = 64;
  localparam int PIN_W    = 64;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] REG_CMD     = 8'h00;
  localparam logic [7:0] REG_PARAM   = 8'h04;
  localparam logic [7:0] REG_DATA0   = 8'h08;
  localparam logic [7:0] REG_DATA3   = 8'h14;
  localparam logic [7:0] REG_STATUS  = 8'h18;
  localparam logic [7:0] REG_ACCRULE = 8'h1C;
  localparam logic [7:0] REG_ACCSTAT = 8'h20;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CMD_OP_LSB      = 0;
  localparam int CMD_LC_LSB      = 8;
  localparam int PARAM_P1_LSB    = 0;
  localparam int PARAM_P2_LSB    = 8;
  localparam int ACC_REFA_LSB    = 0;
  localparam int ACC_REFB_LSB    = 8;
  localparam int ACC_TWO_BIT     = 16;
  localparam int STATUS_BUSY_BIT = 16;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]          LC_RST   = 8'h00;
  localparam logic [7:0]          P_RST    = 8'h00;
  localparam logic [DATA_W-1:0]   WORD_RST = 32'h00000000;
  localparam logic [15:0]         SW_RST   = 16'h0000;
  localparam logic [16:0]         ACC_RST  = 17'h00000;
  localparam logic [NUM_KEYS-1:0] VER_RST  = 64'h0000000000000000;

  // ****************************************
  // command coding
  // ****************************************
  localparam logic [7:0] LC_EMPTY   = 8'h00;
  localparam logic [7:0] LC_ONE_PIN = 8'h08;
  localparam logic [7:0] LC_TWO_PIN = 8'h10;
  localparam logic [1:0] RETRY_INIT = 2'h3;

  localparam logic [15:0] SW_OK         = 16'h9000;
  localparam logic [15:0] SW_RETRY_BASE = 16'h63C0;
  localparam logic [15:0] SW_BLOCKED    = 16'h6983;
  localparam logic [15:0] SW_COND       = 16'h6985;
  localparam logic [15:0] SW_PARAM      = 16'h6B00;
  localparam logic [15:0] SW_LEN        = 16'h6700;
  localparam logic [15:0] SW_INS        = 16'h6D00;

  typedef enum logic [2:0] {
    OP_VERIFY,
    OP_CHANGE,
    OP_DISABLE,
    OP_PROVISION,
    OP_UNBLOCK
  } pvm_op_t;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } pvm_state_t;

endpackage

// [src/pvm_pin_compare.sv]
`timescale 1ns/1ns
module pvm_pin_compare (
  input  wire logic [pvm_pkg::PIN_W-1:0] presented,
  input  wire logic [pvm_pkg::PIN_W-1:0] reference,
  input  wire logic [1:0]                count,
  output logic                           match,
  output logic [1:0]                     countDec,
  output logic                           lastTry
);

  logic [7:0] byteEq;

  // ****************************************
  // byte-wise compare, no early exit
  // ****************************************
  genvar gi;
  for (gi = 0; gi < 8; gi++) begin : g_byte
    assign byteEq[gi] = (presented[8*gi +: 8] == reference[8*gi +: 8]);
  end

  assign match    = &byteEq;
  // saturates so a stray zero count never wraps back to three
  assign countDec = (count == 2'h0) ? 2'h0 : 2'(count - 2'h1);
  assign lastTry  = (count <= 2'h1);

endmodule

// [src/pvm_top.sv]
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ns
// Function
// - check compares only on enabled, unblocked PIN
// - PIN condition needs prior successful check; unblock also satisfies it
// - failure decrements; third failure blocks, 63C0
// - check on blocked PIN answers 6983
// - blocked PIN condition unsatisfiable until unblock
// - empty check reports 63CX retries left
// - failed compare returns retries in low nibble
// - P2 b8 scope, b7-b6 zero, ref 01-1F
// - replace refused if disabled or blocked
// - replace match: counter 3, store new PIN
// - replace miss: decrement, keep PIN, block
// - disable refused if disabled or blocked
// - disable match: counter 3, mark disabled
// - disable miss: decrement, stay enabled, block
// - disabled PIN grants access unless replaced
// - replacement key must be checked instead
// - multi-key rule: any disabled grants access
// - disable P1 b8 selects replacement key
module pvm_top (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [pvm_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [pvm_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [pvm_pkg::DATA_W-1:0]  regRdata,
  output logic                             swValid,
  output logic                             accessGranted
);

  // ****************************************
  // state
  // ****************************************
  pvm_pkg::pvm_state_t          stateQ;
  pvm_pkg::pvm_op_t             opQ;
  logic [7:0]                   lcQ;
  logic [7:0]                   p1Q;
  logic [7:0]                   p2Q;
  logic [pvm_pkg::DATA_W-1:0]   dataQ [4];
  logic [15:0]                  swQ;
  logic                         swValidQ;
  logic [16:0]                  accRuleQ;
  logic                         accessGrantedQ;
  logic [pvm_pkg::NUM_KEYS-1:0] verifiedQ;
  logic [pvm_pkg::DATA_W-1:0]   regRdataQ;

  // persistent per-key store, deliberately without reset
  logic [pvm_pkg::PIN_W-1:0]    pinMem    [pvm_pkg::NUM_KEYS];
  logic [1:0]                   cntMem    [pvm_pkg::NUM_KEYS];
  logic                         disMem    [pvm_pkg::NUM_KEYS];
  logic                         blkMem    [pvm_pkg::NUM_KEYS];
  logic                         altVldMem [pvm_pkg::NUM_KEYS];
  logic [4:0]                   altRefMem [pvm_pkg::NUM_KEYS];

  // ****************************************
  // bus decode
  // ****************************************
  wire logic       wrCmd   = regWr && (regAddr == pvm_pkg::REG_CMD);
  wire logic       wrParam = regWr && (regAddr == pvm_pkg::REG_PARAM);
  wire logic       wrAcc   = regWr && (regAddr == pvm_pkg::REG_ACCRULE);
  wire logic       cmdTake = wrCmd && (stateQ == pvm_pkg::ST_IDLE);
  wire logic       execQ   = (stateQ == pvm_pkg::ST_EXEC);
  wire logic       isData  = (regAddr >= pvm_pkg::REG_DATA0) && (regAddr <= pvm_pkg::REG_DATA3);
  // data words sit at 08..14: flipping bit 1 of the word index (address bit 3) maps them to 0..3
  wire logic [1:0] dataIdx = regAddr[3:2] ^ 2'h2;

  logic [3:0] dataWr;

  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_data
    assign dataWr[gi] = regWr && isData && (dataIdx == 2'(gi));
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        dataQ[gi] <= pvm_pkg::WORD_RST;
      end else if (dataWr[gi]) begin
        dataQ[gi] <= regWdata;
      end
    end
  end

  // ****************************************
  // command fields and addressed key
  // ****************************************
  wire logic [pvm_pkg::KEY_W-1:0] keyIdx = {p2Q[7], p2Q[4:0]};
  wire logic p2Ok = (p2Q[6:5] == 2'h0) && (p2Q[4:0] != 5'h00);
  wire logic p1Ok = (p1Q[6:5] == 2'h0)
                    && ((p1Q == 8'h00) || (p1Q[7] && (p1Q[4:0] != 5'h00)));

  wire logic [pvm_pkg::PIN_W-1:0] presented = {dataQ[1], dataQ[0]};
  wire logic [pvm_pkg::PIN_W-1:0] newPin    = {dataQ[3], dataQ[2]};
  wire logic [pvm_pkg::PIN_W-1:0] curPin    = pinMem[keyIdx];
  wire logic [1:0]                curCnt    = cntMem[keyIdx];
  wire logic                      curDis    = disMem[keyIdx];
  wire logic                      curBlk    = blkMem[keyIdx];
  wire logic                      curAltVld = altVldMem[keyIdx];
  wire logic [4:0]                curAltRef = altRefMem[keyIdx];

  logic       pinMatch;
  logic [1:0] cntDec;
  logic       lastTry;

  pvm_pin_compare u_cmp (
    .presented (presented),
    .reference (curPin),
    .count     (curCnt),
    .match     (pinMatch),
    .countDec  (cntDec),
    .lastTry   (lastTry)
  );

  // ****************************************
  // command decision
  // ****************************************
  logic [15:0]               swD;
  logic                      doCmp;
  logic                      wrEntry;
  logic [pvm_pkg::PIN_W-1:0] pinD;
  logic [1:0]                cntD;
  logic                      disD;
  logic                      blkD;
  logic                      altVldD;
  logic [4:0]                altRefD;
  logic                      verSet;
  logic                      verClr;

  always_comb begin
    swD     = pvm_pkg::SW_OK;
    doCmp   = 1'b0;
    wrEntry = 1'b0;
    pinD    = curPin;
    cntD    = curCnt;
    disD    = curDis;
    blkD    = curBlk;
    altVldD = curAltVld;
    altRefD = curAltRef;
    verSet  = 1'b0;
    verClr  = 1'b0;
    case (opQ)
      pvm_pkg::OP_VERIFY: begin
        if ((p1Q != 8'h00) || !p2Ok) begin
          swD = pvm_pkg::SW_PARAM;
        end else if (lcQ == pvm_pkg::LC_EMPTY) begin
          swD = pvm_pkg::SW_RETRY_BASE | {14'h0000, curCnt};
        end else if (lcQ != pvm_pkg::LC_ONE_PIN) begin
          swD = pvm_pkg::SW_LEN;
        end else if (curBlk) begin
          swD = pvm_pkg::SW_BLOCKED;
        end else if (curDis) begin
          swD = pvm_pkg::SW_COND;
        end else begin
          doCmp = 1'b1;
        end
      end
      pvm_pkg::OP_CHANGE: begin
        if ((p1Q != 8'h00) || !p2Ok) begin
          swD = pvm_pkg::SW_PARAM;
        end else if (lcQ != pvm_pkg::LC_TWO_PIN) begin
          swD = pvm_pkg::SW_LEN;
        end else if (curBlk) begin
          swD = pvm_pkg::SW_BLOCKED;
        end else if (curDis) begin
          swD = pvm_pkg::SW_COND;
        end else begin
          doCmp = 1'b1;
        end
      end
      pvm_pkg::OP_DISABLE: begin
        if (!p1Ok || !p2Ok) begin
          swD = pvm_pkg::SW_PARAM;
        end else if (lcQ != pvm_pkg::LC_ONE_PIN) begin
          swD = pvm_pkg::SW_LEN;
        end else if (curDis || curBlk) begin
          swD = pvm_pkg::SW_COND;
        end else begin
          doCmp = 1'b1;
        end
      end
      pvm_pkg::OP_PROVISION: begin
        if (!p2Ok) begin
          swD = pvm_pkg::SW_PARAM;
        end else begin
          wrEntry = 1'b1;
          pinD    = presented;
          cntD    = pvm_pkg::RETRY_INIT;
          disD    = 1'b0;
          blkD    = 1'b0;
          altVldD = 1'b0;
          verClr  = 1'b1;
        end
      end
      pvm_pkg::OP_UNBLOCK: begin
        if (!p2Ok) begin
          swD = pvm_pkg::SW_PARAM;
        end else begin
          // completed unblock re-enables the key and satisfies its condition
          wrEntry = 1'b1;
          cntD    = pvm_pkg::RETRY_INIT;
          disD    = 1'b0;
          blkD    = 1'b0;
          altVldD = 1'b0;
          verSet  = 1'b1;
        end
      end
      default: begin
        swD = pvm_pkg::SW_INS;
      end
    endcase
    if (doCmp) begin
      wrEntry = 1'b1;
      if (pinMatch) begin
        cntD = pvm_pkg::RETRY_INIT;
        if (opQ == pvm_pkg::OP_VERIFY) begin
          verSet = 1'b1;
        end
        if (opQ == pvm_pkg::OP_CHANGE) begin
          pinD = newPin;
        end
        if (opQ == pvm_pkg::OP_DISABLE) begin
          disD    = 1'b1;
          altVldD = p1Q[7];
          altRefD = p1Q[4:0];
        end
      end else begin
        // a miss also drops any earlier success on this key
        cntD   = cntDec;
        blkD   = lastTry;
        verClr = 1'b1;
        swD    = pvm_pkg::SW_RETRY_BASE | {14'h0000, cntDec};
      end
    end
  end

  // ****************************************
  // persistent store
  // ****************************************
  // no reset: counters and flags must survive reset and sessions
  always_ff @(posedge mclk) begin
    if (execQ && wrEntry) begin
      pinMem[keyIdx]    <= pinD;
      cntMem[keyIdx]    <= cntD;
      disMem[keyIdx]    <= disD;
      blkMem[keyIdx]    <= blkD;
      altVldMem[keyIdx] <= altVldD;
      altRefMem[keyIdx] <= altRefD;
    end
  end

  // ****************************************
  // sequencer and session state
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stateQ   <= pvm_pkg::ST_IDLE;
      opQ      <= pvm_pkg::OP_VERIFY;
      lcQ      <= pvm_pkg::LC_RST;
      swQ      <= pvm_pkg::SW_RST;
      swValidQ <= 1'b0;
    end else begin
      swValidQ <= execQ;
      case (stateQ)
        pvm_pkg::ST_IDLE: begin
          if (cmdTake) begin
            opQ    <= pvm_pkg::pvm_op_t'(regWdata[pvm_pkg::CMD_OP_LSB +: 3]);
            lcQ    <= regWdata[pvm_pkg::CMD_LC_LSB +: 8];
            stateQ <= pvm_pkg::ST_EXEC;
          end
        end
        pvm_pkg::ST_EXEC: begin
          swQ    <= swD;
          stateQ <= pvm_pkg::ST_IDLE;
        end
        default: begin
          stateQ <= pvm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // verified flags are per session, so reset clears them
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      verifiedQ <= pvm_pkg::VER_RST;
    end else if (execQ && verSet) begin
      verifiedQ[keyIdx] <= 1'b1;
    end else if (execQ && verClr) begin
      verifiedQ[keyIdx] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      p1Q      <= pvm_pkg::P_RST;
      p2Q      <= pvm_pkg::P_RST;
      accRuleQ <= pvm_pkg::ACC_RST;
    end else begin
      if (wrParam && !execQ) begin
        p1Q <= regWdata[pvm_pkg::PARAM_P1_LSB +: 8];
        p2Q <= regWdata[pvm_pkg::PARAM_P2_LSB +: 8];
      end
      if (wrAcc) begin
        accRuleQ <= regWdata[16:0];
      end
    end
  end

  // ****************************************
  // access evaluation
  // ****************************************
  wire logic [pvm_pkg::KEY_W-1:0] refA   = accRuleQ[pvm_pkg::ACC_REFA_LSB +: 6];
  wire logic [pvm_pkg::KEY_W-1:0] refB   = accRuleQ[pvm_pkg::ACC_REFB_LSB +: 6];
  wire logic                      accTwo = accRuleQ[pvm_pkg::ACC_TWO_BIT];
  wire logic [pvm_pkg::KEY_W-1:0] altIdx = {1'b0, altRefMem[refA]};
  wire logic okA = !blkMem[refA] && verifiedQ[refA];
  wire logic okB = !blkMem[refB] && verifiedQ[refB];
  wire logic altOk = disMem[altIdx] || (!blkMem[altIdx] && verifiedQ[altIdx]);
  wire logic singleGrant = disMem[refA] ? (altVldMem[refA] ? altOk : 1'b1) : okA;
  wire logic twoGrant = disMem[refA] || disMem[refB] || okA || okB;
  wire logic grantD = accTwo ? twoGrant : singleGrant;

  // ****************************************
  // read path
  // ****************************************
  wire logic [31:0] cmdRd  = {16'h0000, lcQ, 5'h00, opQ};
  wire logic [31:0] parRd  = {16'h0000, p2Q, p1Q};
  wire logic [31:0] statRd = {15'h0000, execQ, swQ};
  wire logic [31:0] rdMux  =
      (regAddr == pvm_pkg::REG_CMD)     ? cmdRd :
      (regAddr == pvm_pkg::REG_PARAM)   ? parRd :
      isData                            ? dataQ[dataIdx] :
      (regAddr == pvm_pkg::REG_STATUS)  ? statRd :
      (regAddr == pvm_pkg::REG_ACCRULE) ? {15'h0000, accRuleQ} :
      (regAddr == pvm_pkg::REG_ACCSTAT) ? {31'h00000000, accessGrantedQ} :
                                          pvm_pkg::WORD_RST;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdataQ      <= pvm_pkg::WORD_RST;
      accessGrantedQ <= 1'b0;
    end else begin
      regRdataQ      <= regRd ? rdMux : pvm_pkg::WORD_RST;
      accessGrantedQ <= grantD;
    end
  end

  assign regRdata      = regRdataQ;
  assign swValid       = swValidQ;
  assign accessGranted = accessGrantedQ;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence sCmdTaken;
    cmdTake ##1 execQ;
  endsequence

  sequence sBlockedCheck;
    execQ && (opQ == pvm_pkg::OP_VERIFY) && (lcQ == pvm_pkg::LC_ONE_PIN)
      && (p1Q == 8'h00) && p2Ok && curBlk;
  endsequence

  AST_BLOCKED_CHECK: assert property (
    (sCmdTaken ##0 sBlockedCheck) |=> swValidQ && (swQ == pvm_pkg::SW_BLOCKED)
      && (cntMem[$past(keyIdx)] == $past(curCnt)))
    else $error("blocked check not answered 6983");

  AST_THIRD_FAIL: assert property (
    execQ && doCmp && (opQ == pvm_pkg::OP_VERIFY) && !pinMatch && (curCnt == 2'h1)
      |=> blkMem[$past(keyIdx)] && (swQ == pvm_pkg::SW_RETRY_BASE))
    else $error("third failure did not block");

  AST_FAIL_COUNT: assert property (
    execQ && doCmp && !pinMatch && (curCnt == 2'h3)
      |=> (cntMem[$past(keyIdx)] == 2'h2) && (swQ == 16'h63C2))
    else $error("retry count not reported after miss");

  AST_RETRY_QUERY: assert property (
    execQ && (opQ == pvm_pkg::OP_VERIFY) && (p1Q == 8'h00) && p2Ok
      && (lcQ == pvm_pkg::LC_EMPTY)
      |=> (swQ[15:4] == 12'h63C) && (swQ[3:0] == {2'h0, $past(curCnt)}))
    else $error("empty check did not report retries");

  AST_NO_CMP_DISABLED: assert property (
    execQ && (opQ == pvm_pkg::OP_VERIFY) && (lcQ == pvm_pkg::LC_ONE_PIN)
      && (p1Q == 8'h00) && p2Ok && curDis && !curBlk
      |=> (swQ == pvm_pkg::SW_COND) && (cntMem[$past(keyIdx)] == $past(curCnt)))
    else $error("disabled key was compared");

  AST_CHANGE_OK: assert property (
    execQ && doCmp && (opQ == pvm_pkg::OP_CHANGE) && pinMatch
      |=> (pinMem[$past(keyIdx)] == $past(newPin))
      && (cntMem[$past(keyIdx)] == pvm_pkg::RETRY_INIT))
    else $error("replace did not store new value");

  AST_CHANGE_MISS: assert property (
    execQ && doCmp && (opQ == pvm_pkg::OP_CHANGE) && !pinMatch
      |=> pinMem[$past(keyIdx)] == $past(curPin))
    else $error("failed replace altered stored value");

  AST_DISABLE_REFUSE: assert property (
    execQ && (opQ == pvm_pkg::OP_DISABLE) && p1Ok && p2Ok
      && (lcQ == pvm_pkg::LC_ONE_PIN) && (curDis || curBlk)
      |=> (swQ == pvm_pkg::SW_COND) && (disMem[$past(keyIdx)] == $past(curDis)))
    else $error("disable executed on disabled or blocked key");

  AST_DISABLE_OK: assert property (
    execQ && doCmp && (opQ == pvm_pkg::OP_DISABLE) && pinMatch
      |=> disMem[$past(keyIdx)] && (cntMem[$past(keyIdx)] == pvm_pkg::RETRY_INIT))
    else $error("disable with good value failed");

  AST_BLOCKED_DENY: assert property (
    !accTwo && blkMem[refA] && !disMem[refA] && !wrAcc && !execQ
      |-> !grantD ##1 !accessGrantedQ)
    else $error("blocked key granted access");

  AST_DISABLED_FREE: assert property (
    !accTwo && disMem[refA] && !altVldMem[refA] |-> grantD)
    else $error("disabled key without replacement not free");

  AST_ALT_NEEDED: assert property (
    !accTwo && disMem[refA] && altVldMem[refA] && !verifiedQ[altIdx]
      && !disMem[altIdx] |-> !grantD)
    else $error("replacement key not required");

  AST_TWO_REFS: assert property (
    accTwo && (disMem[refA] || disMem[refB]) |-> grantD)
    else $error("multi-key rule not free after disable");

endmodule

// [test/pvm_terminal.sv]
`timescale 1ns/1ns
module pvm_terminal (
  input  wire logic        mclk,
  input  wire logic        swValid,
  input  wire logic [31:0] regRdata,
  output logic      [7:0]  regAddr,
  output logic      [31:0] regWdata,
  output logic             regWr,
  output logic             regRd
);
  initial begin
    regAddr  = 8'h00;
    regWdata = 32'h00000000;
    regWr    = 1'b0;
    regRd    = 1'b0;
  end

  // ****************************************
  // bus cycles
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  // ****************************************
  // one command message
  // ****************************************
  // data words always written, so a short Lc never reuses stale bytes by accident
  task automatic issue(input logic [2:0] op, input logic [7:0] lc, p1, p2,
                       input logic [63:0] p, np, output logic [15:0] sw, output logic seen);
    logic [31:0] d;
    wr(8'h04, {16'h0000, p2, p1});
    wr(8'h08, p[31:0]);
    wr(8'h0C, p[63:32]);
    wr(8'h10, np[31:0]);
    wr(8'h14, np[63:32]);
    wr(8'h00, {16'h0000, lc, 5'h00, op});
    seen = 1'b0;
    for (int i = 0; i < 6 && !seen; i++) begin
      @(posedge mclk);
      #1 seen = swValid;
    end
    rd(8'h18, d);
    sw = d[15:0];
  endtask
endmodule

// [test/pin_verification_manager_tb_top.sv]
`timescale 1ns/1ns
module pin_verification_manager_tb_top;
  logic        mclk, rst, regWr, regRd, swValid, accessGranted;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, rdw;
  logic [63:0] pv[64];
  logic [63:0] pa, pb, pc, pd, bad;
  int          num_errors, compares, cyc, ruleA, ruleB, two;
  int          cnt[64], rep[64];
  bit          dis[64], blk[64], ver[64];

  pvm_top dut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .swValid(swValid),
    .accessGranted(accessGranted));
  pvm_terminal term (.mclk(mclk), .swValid(swValid), .regRdata(regRdata),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ****************************************
  // reference model
  // ****************************************
  function automatic bit sat(input int k);
    if (dis[k]) return (rep[k] < 0) ? 1'b1 : ver[rep[k]];
    if (blk[k]) return 1'b0;
    return ver[k];
  endfunction

  function automatic bit acc();
    if (two != 0) return dis[ruleA] || dis[ruleB] || sat(ruleA) || sat(ruleB);
    return sat(ruleA);
  endfunction

  task automatic model(input int op, lc, p1, p2, input logic [63:0] p, np, output int e);
    int k;
    bit bp;
    k = (p2 >> 7) * 32 + (p2 & 31);
    bp = (p2 & 'h60) != 0 || (p2 & 31) == 0;
    if (op == 2) bp |= (p1 & 'h60) != 0 || (p1 != 0 && (p1 < 'h80 || (p1 & 31) == 0));
    else if (op < 2) bp |= p1 != 0;
    if (op > 4) e = 'h6D00;
    else if (bp) e = 'h6B00;
    else if (op >= 3) begin
      if (op == 3) pv[k] = p;
      cnt[k] = 3;
      dis[k] = 0;
      blk[k] = 0;
      rep[k] = -1;
      ver[k] = op == 4;
      e = 'h9000;
    end
    else if (op == 0 && lc == 0) e = 'h63C0 + cnt[k];
    else if (lc != ((op == 1) ? 16 : 8)) e = 'h6700;
    else if (blk[k]) e = (op == 2) ? 'h6985 : 'h6983;
    else if (dis[k]) e = 'h6985;
    else if (p == pv[k]) begin
      e = 'h9000;
      cnt[k] = 3;
      if (op == 0) ver[k] = 1;
      if (op == 1) pv[k] = np;
      if (op == 2) dis[k] = 1;
      if (op == 2) rep[k] = p1[7] ? (p1 & 31) : -1;
    end
    else begin
      cnt[k]--;
      ver[k] = 0;
      blk[k] = cnt[k] == 0;
      e = 'h63C0 + cnt[k];
    end
  endtask

  task automatic run(input int op, lc, p1, p2, input logic [63:0] p, np);
    int e;
    logic [15:0] sw;
    logic seen;
    model(op, lc, p1, p2, p, np, e);
    term.issue(op[2:0], lc[7:0], p1[7:0], p2[7:0], p, np, sw, seen);
    check({31'h00000000, seen}, 32'h00000001);
    check({16'h0000, sw}, e[31:0]);
    check({31'h00000000, accessGranted}, {31'h00000000, acc()});
  endtask

  // access rule change needs the registered flag to settle first
  task automatic rule(input int a, b, t);
    ruleA = a;
    ruleB = b;
    two = t;
    term.wr(8'h1C, {15'h0000, t[0], 2'h0, b[5:0], 2'h0, a[5:0]});
    repeat (2) @(posedge mclk);
    term.rd(8'h20, rdw);
    check(rdw, {31'h00000000, acc()});
  endtask

  // session end: store must survive reset, verified flags and access rule must not
  task automatic session();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    foreach (ver[i]) ver[i] = 0;
    rule(ruleA, ruleB, two);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    num_errors = 0;
    compares = 0;
    ruleA = 1;
    ruleB = 0;
    two = 0;
    void'($urandom(5));
    pa = {$urandom, $urandom};
    pb = {$urandom, $urandom};
    pc = {$urandom, $urandom};
    pd = {$urandom, $urandom};
    bad = {$urandom, $urandom};
    foreach (rep[i]) rep[i] = -1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    // a rule on a never provisioned key reads unknown store contents
    term.wr(8'h1C, 32'h00000001);
    run(3, 8, 0, 'h01, pa, 0);
    run(3, 8, 0, 'h81, pb, 0);
    run(3, 8, 0, 'h02, pc, 0);
    run(3, 8, 0, 'h03, pd, 0);
    rule(1, 0, 0);
    run(0, 0, 0, 1, 0, 0);
    run(0, 8, 0, 1, bad, 0);
    run(0, 8, 0, 1, pa, 0);
    run(1, 16, 0, 1, bad, pc);
    run(1, 16, 0, 1, pa, pd);
    run(0, 8, 0, 1, pa, 0);
    run(0, 8, 0, 1, pd, 0);
    repeat (2) run(0, 8, 0, 'h81, bad, 0);
    session();
    run(0, 0, 0, 'h81, 0, 0);
    run(0, 8, 0, 'h81, bad, 0);
    run(0, 8, 0, 'h81, pb, 0);
    run(0, 0, 0, 'h81, 0, 0);
    run(1, 16, 0, 'h81, pb, pa);
    run(2, 8, 0, 'h81, pb, 0);
    rule(33, 0, 0);
    run(2, 8, 0, 3, bad, 0);
    run(2, 8, 0, 3, pd, 0);
    run(2, 8, 0, 3, pd, 0);
    run(0, 8, 0, 3, pd, 0);
    run(1, 16, 0, 3, pd, pa);
    run(4, 0, 0, 'h81, 0, 0);
    rule(3, 0, 0);
    rule(1, 0, 0);
    run(2, 8, 'h82, 1, pd, 0);
    run(0, 8, 0, 2, pc, 0);
    rule(33, 3, 1);
    rule(33, 1, 1);
    run(0, 8, 0, 'h00, pc, 0);
    run(0, 8, 0, 'h42, pc, 0);
    run(0, 8, 1, 2, pc, 0);
    run(0, 4, 0, 2, pc, 0);
    run(5, 8, 0, 2, pc, 0);
    run(2, 8, 1, 2, pc, 0);
    run(2, 8, 'h80, 2, pc, 0);
    term.rd(8'h40, rdw);
    check(rdw, 32'h00000000);
    report_and_stop();
  end
endmodule
